// *** core/sfo_otp_ctrl.sv ***
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module sfo_otp_ctrl #(
    parameter int PUW_CYCLES = sfo_pkg::PUW_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_opcode,
    input  wire logic [22:0] cmd_addr,
    input  wire logic [7:0]  cmd_wdata,
    input  wire logic        cmd_quad,
    input  wire logic        quad_command_mode,
    output logic             cmd_done_q,
    output logic             cmd_ok_q,
    output logic             otp_sel_q,
    output logic [22:0]      map_addr_q,
    output logic [7:0]       status_out_q,
    output logic             otp_mode_q,
    output logic             otp_lock_q
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic        wel_q;
    logic [3:0]  bp_q;
    logic        srp_q;
    logic        inh_q;
    logic [16:0] puw_cnt_q;
    logic        puw_done_q;
    logic [7:0]  last_op_q;
    logic        last_ref_q;

    logic        take;
    logic        in_otp;
    logic        in_otp_blk;
    logic        is_wr;
    logic        wr_open;
    logic        ok;
    logic [7:0]  stat_now;

    assign take = ce && cmd_valid;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Address lands in the secure sector window
    assign in_otp = (cmd_addr >= sfo_pkg::OTP_BASE)
                 && (cmd_addr <= sfo_pkg::OTP_LAST);
    assign in_otp_blk = cmd_addr[22:sfo_pkg::BLK_LSB] == sfo_pkg::OTP_BLK;
    assign is_wr = cmd_opcode == sfo_pkg::OP_PP || cmd_opcode == sfo_pkg::OP_SE
                || cmd_opcode == sfo_pkg::OP_BE || cmd_opcode == sfo_pkg::OP_CE
                || cmd_opcode == sfo_pkg::OP_STATUS_WRITE_CMD;
    // Writes need the latch, the power-up wait over and no inhibit
    assign wr_open = wel_q && puw_done_q && !inh_q;

    // Status byte as a status read would return it
    always_comb begin
        stat_now = sfo_pkg::ST_RST;
        stat_now[sfo_pkg::ST_WEL] = wel_q;
        stat_now[sfo_pkg::ST_BP +: 4] = bp_q;
        stat_now[sfo_pkg::ST_SP] = otp_mode_q ? otp_lock_q : srp_q;
    end

    // Acceptance of the instruction
    always_comb begin
        ok = 1'b1;
        if (is_wr && !wr_open) begin
            ok = 1'b0;
        end else if (cmd_opcode == sfo_pkg::OP_OTP) begin
            ok = !quad_command_mode || cmd_quad;
        end else if (otp_mode_q && cmd_opcode != sfo_pkg::OP_STATUS_WRITE_CMD && is_wr) begin
            if (otp_lock_q) begin
                ok = 1'b0;
            end else if (cmd_opcode == sfo_pkg::OP_CE) begin
                ok = 1'b0;
            end else if (cmd_opcode == sfo_pkg::OP_BE) begin
                ok = !in_otp_blk;
            end else if (in_otp) begin
                ok = bp_q == sfo_pkg::BP_NONE;
            end
        end else if (cmd_opcode == sfo_pkg::OP_CE) begin
            ok = bp_q == sfo_pkg::BP_NONE;
        end
    end

    // ----------------------------------------
    // Power-up write wait
    // ----------------------------------------
    // Counts from reset release; writes refused until done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            puw_cnt_q  <= '0;
            puw_done_q <= 1'b0;
        end else if (ce && !puw_done_q) begin
            puw_cnt_q  <= puw_cnt_q + 17'h00001;
            puw_done_q <= 32'(puw_cnt_q) >= PUW_CYCLES - 1;
        end
    end

    // ----------------------------------------
    // Mode and lock
    // ----------------------------------------
    // Secure mode entry and exit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            otp_mode_q <= 1'b0;
        end else if (take && ok) begin
            if (cmd_opcode == sfo_pkg::OP_OTP) begin
                otp_mode_q <= 1'b1;
            end else if (cmd_opcode == sfo_pkg::OP_WRITE_DISABLE_CMD) begin
                otp_mode_q <= 1'b0;
            end
        end
    end

    // Lock only ever sets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            otp_lock_q <= 1'b0;
        end else if (take && ok && otp_mode_q && cmd_opcode == sfo_pkg::OP_STATUS_WRITE_CMD) begin
            otp_lock_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Status register
    // ----------------------------------------
    // Write latch, protect field and protect bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wel_q <= 1'b0;
            bp_q  <= sfo_pkg::BP_NONE;
            srp_q <= 1'b0;
        end else if (take && ok) begin
            if (cmd_opcode == sfo_pkg::OP_WREN) begin
                wel_q <= 1'b1;
            end else if (cmd_opcode == sfo_pkg::OP_WRITE_DISABLE_CMD || is_wr) begin
                wel_q <= 1'b0;
            end
            if (cmd_opcode == sfo_pkg::OP_STATUS_WRITE_CMD && !otp_mode_q) begin
                bp_q  <= cmd_wdata[sfo_pkg::ST_BP +: 4];
                srp_q <= cmd_wdata[sfo_pkg::ST_SP];
            end
        end
    end

    // ----------------------------------------
    // Answer to the instruction path
    // ----------------------------------------
    // One-cycle completion with routing and status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_done_q   <= 1'b0;
            cmd_ok_q     <= 1'b0;
            otp_sel_q    <= 1'b0;
            map_addr_q   <= '0;
            status_out_q <= sfo_pkg::ST_RST;
        end else if (ce) begin
            cmd_done_q <= cmd_valid;
            if (cmd_valid) begin
                cmd_ok_q     <= ok;
                otp_sel_q    <= ok && otp_mode_q && in_otp
                             && cmd_opcode != sfo_pkg::OP_WRITE_DISABLE_CMD;
                map_addr_q   <= cmd_addr;
                status_out_q <= stat_now;
            end
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign pready  = 1'b1;
    assign pslverr = psel && penable && paddr != sfo_pkg::REG_STAT
                  && paddr != sfo_pkg::REG_CFG && paddr != sfo_pkg::REG_LAST;

    // Software write inhibit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inh_q <= 1'b0;
        end else if (ce && psel && penable && pwrite && paddr == sfo_pkg::REG_CFG) begin
            inh_q <= pwdata[sfo_pkg::CFG_INH];
        end
    end

    // Last instruction record
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_op_q  <= '0;
            last_ref_q <= 1'b0;
        end else if (take) begin
            last_op_q  <= cmd_opcode;
            last_ref_q <= !ok;
        end
    end

    // Read data decode
    always_comb begin
        prdata = '0;
        case (paddr)
            sfo_pkg::REG_STAT: begin
                prdata[7:0]            = stat_now;
                prdata[sfo_pkg::SS_OTP]  = otp_mode_q;
                prdata[sfo_pkg::SS_LOCK] = otp_lock_q;
                prdata[sfo_pkg::SS_PUW]  = puw_done_q;
            end
            sfo_pkg::REG_CFG: begin
                prdata[sfo_pkg::CFG_INH] = inh_q;
            end
            sfo_pkg::REG_LAST: begin
                prdata[7:0]             = last_op_q;
                prdata[sfo_pkg::LS_OK]  = cmd_ok_q;
                prdata[sfo_pkg::LS_REF] = last_ref_q;
            end
            default: prdata = '0;
        endcase
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    lock_sticky_a: assert property (
        otp_lock_q |=> otp_lock_q)
        else $error("lock cleared");
    otp_enter_a: assert property (
        take && cmd_opcode == sfo_pkg::OP_OTP && !quad_command_mode |=> otp_mode_q)
        else $error("enter ignored");
    otp_exit_a: assert property (
        take && cmd_opcode == sfo_pkg::OP_WRITE_DISABLE_CMD |=> !otp_mode_q ##1 !otp_sel_q)
        else $error("exit ignored");
    lock_refuse_a: assert property (
        take && otp_mode_q && otp_lock_q && in_otp
        && (cmd_opcode == sfo_pkg::OP_PP || cmd_opcode == sfo_pkg::OP_SE)
        |=> cmd_done_q && !cmd_ok_q)
        else $error("locked sector written");
    bp_gate_a: assert property (
        take && otp_mode_q && in_otp && cmd_opcode == sfo_pkg::OP_PP
        && bp_q != sfo_pkg::BP_NONE |=> !cmd_ok_q)
        else $error("protect field ignored");
    status_write_cmd_drop_a: assert property (
        take && otp_mode_q && cmd_opcode == sfo_pkg::OP_STATUS_WRITE_CMD && wr_open
        |=> otp_lock_q && $stable(bp_q))
        else $error("status write in secure mode");
    ce_only_a: assert property (
        take && otp_mode_q && cmd_opcode == sfo_pkg::OP_CE |=> !cmd_ok_q)
        else $error("chip erase in secure mode");
    stat_lock_a: assert property (
        take && otp_mode_q && cmd_opcode == sfo_pkg::OP_STATUS_READ_CMD
        |=> status_out_q[sfo_pkg::ST_SP] == otp_lock_q)
        else $error("lock not in status");
    puw_block_a: assert property (
        take && !puw_done_q && is_wr |=> !cmd_ok_q)
        else $error("write in power-up wait");
    quad_a: assert property (
        take && quad_command_mode && cmd_quad && cmd_opcode == sfo_pkg::OP_OTP
        |=> cmd_ok_q ##0 otp_mode_q)
        else $error("quad enter refused");
    quad_refuse_a: assert property (
        take && quad_command_mode && !cmd_quad && cmd_opcode == sfo_pkg::OP_OTP
        |=> !cmd_ok_q && $stable(otp_mode_q))
        else $error("single-line enter taken in quad mode");

    // Mapping and routing of the secure sector
    sel_map_a: assert property (
        take && otp_mode_q && in_otp && cmd_opcode == sfo_pkg::OP_READ
        |=> cmd_ok_q && otp_sel_q && map_addr_q == $past(cmd_addr))
        else $error("secure sector not mapped");
    sel_plain_a: assert property (
        take && !otp_mode_q |=> !otp_sel_q)
        else $error("secure sector mapped outside secure mode");
    other_read_a: assert property (
        take && otp_mode_q && cmd_opcode == sfo_pkg::OP_READ && !in_otp
        |=> cmd_ok_q && !otp_sel_q)
        else $error("other sector read refused");

    // Write gating by lock, protect field, latch and inhibit
    other_write_a: assert property (
        take && otp_mode_q && otp_lock_q && !in_otp
        && (cmd_opcode == sfo_pkg::OP_PP || cmd_opcode == sfo_pkg::OP_SE)
        |=> !cmd_ok_q)
        else $error("other sector written while locked");
    se_open_a: assert property (
        take && otp_mode_q && in_otp && cmd_opcode == sfo_pkg::OP_SE && wr_open
        && !otp_lock_q && bp_q == sfo_pkg::BP_NONE
        |=> cmd_ok_q && otp_sel_q)
        else $error("secure sector erase refused");
    be_otp_a: assert property (
        take && otp_mode_q && in_otp_blk && cmd_opcode == sfo_pkg::OP_BE |=> !cmd_ok_q)
        else $error("block erase of secure sector");
    srp_keep_a: assert property (
        take && otp_mode_q && cmd_opcode == sfo_pkg::OP_STATUS_WRITE_CMD
        |=> $stable(srp_q) && $stable(bp_q))
        else $error("status data taken in secure mode");
    status_write_cmd_wel_a: assert property (
        take && otp_mode_q && cmd_opcode == sfo_pkg::OP_STATUS_WRITE_CMD && !wr_open
        |=> !cmd_ok_q && $stable(otp_lock_q))
        else $error("lock set without write enable");
    inh_block_a: assert property (
        take && inh_q && is_wr |=> !cmd_ok_q)
        else $error("write taken while inhibited");

    // Mode exit, status meaning, answer and clock enable
    exit_wel_a: assert property (
        take && cmd_opcode == sfo_pkg::OP_WRITE_DISABLE_CMD |=> !wel_q)
        else $error("write latch kept on exit");
    stat_plain_a: assert property (
        take && !otp_mode_q && cmd_opcode == sfo_pkg::OP_STATUS_READ_CMD
        |=> status_out_q[sfo_pkg::ST_SP] == srp_q)
        else $error("protect bit not restored");
    done_next_a: assert property (
        take |=> cmd_done_q)
        else $error("instruction not answered");
    ce_freeze_a: assert property (
        !ce |=> $stable(otp_mode_q) && $stable(otp_lock_q) && $stable(inh_q)
        && $stable(cmd_done_q))
        else $error("state moved while clock enable low");

    // Main scenarios

    enter_c: cover property (take && cmd_opcode == sfo_pkg::OP_OTP ##[1:20] otp_lock_q);
    otp_pp_c: cover property (take && otp_mode_q && in_otp && ok && is_wr);
    exit_c: cover property (otp_mode_q ##1 !otp_mode_q);
    ce_hold_c: cover property (!ce ##1 ce);
    lock_set_c: cover property (!otp_lock_q ##1 otp_lock_q);
endmodule

// *** core/sfo_pkg.sv ***
package sfo_pkg;
    // ----------------------------------------
    // Instruction codes
    // ----------------------------------------
    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE_CMD  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ_CMD  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE_CMD  = 8'h01;
    localparam logic [7:0] OP_READ  = 8'h03;
    localparam logic [7:0] OP_FREAD = 8'h0B;
    localparam logic [7:0] OP_PP    = 8'h02;
    localparam logic [7:0] OP_SE    = 8'h20;
    localparam logic [7:0] OP_BE    = 8'hD8;
    localparam logic [7:0] OP_CE    = 8'hC7;
    localparam logic [7:0] OP_OTP   = 8'h3A;
    // ----------------------------------------
    // Address map
    // ----------------------------------------
    localparam int          ADDR_W   = 23;
    localparam logic [22:0] OTP_BASE = 23'h7FF000;
    localparam logic [22:0] OTP_LAST = 23'h7FF1FF;
    localparam int          BLK_LSB  = 16;
    localparam logic [6:0]  OTP_BLK  = 7'h7F;
    // ----------------------------------------
    // Status byte layout
    // ----------------------------------------
    localparam int         ST_WEL  = 1;
    localparam int         ST_BP   = 2;
    localparam int         ST_SP   = 7;
    localparam logic [7:0] ST_RST  = 8'h00;
    localparam logic [3:0] BP_NONE = 4'h0;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ    = 100;
    localparam int PUW_MIN_US = 1000;
    localparam int PUW_CYC    = PUW_MIN_US * CLK_MHZ;
    // ----------------------------------------
    // APB register map
    // ----------------------------------------
    localparam logic [7:0] REG_STAT = 8'h00;
    localparam logic [7:0] REG_CFG  = 8'h04;
    localparam logic [7:0] REG_LAST = 8'h08;
    localparam int         CFG_INH  = 0;
    localparam int         LS_OK    = 8;
    localparam int         LS_REF   = 9;
    localparam int         SS_OTP   = 8;
    localparam int         SS_LOCK  = 9;
    localparam int         SS_PUW   = 10;
endpackage

// *** sim/sfo_host_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Host side offering decoded instructions
// ----------------------------------------
module sfo_host_model (
    input  wire logic        pclk,
    output logic             cmd_valid,
    output logic [7:0]       cmd_opcode,
    output logic [22:0]      cmd_addr,
    output logic [7:0]       cmd_wdata,
    output logic             cmd_quad,
    output logic             quad_command_mode
);
    // Idle until the bench asks for an instruction
    initial begin
        cmd_valid         = 1'b0;
        cmd_opcode        = 8'h00;
        cmd_addr          = 23'h000000;
        cmd_wdata         = 8'h00;
        cmd_quad          = 1'b0;
        quad_command_mode = 1'b0;
    end
    // One-cycle offer; address and data flip afterwards so stale values never look valid
    task automatic send(input logic [7:0] op, input logic [22:0] a, input logic [7:0] d,
                        input logic q, input logic qm);
        @(posedge pclk);
        cmd_valid         <= 1'b1;
        cmd_opcode        <= op;
        cmd_addr          <= a;
        cmd_wdata         <= d;
        cmd_quad          <= q;
        quad_command_mode <= qm;
        @(posedge pclk);
        cmd_valid         <= 1'b0;
        cmd_addr          <= ~a;
        cmd_wdata         <= ~d;
    endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ns
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, cmd_opcode, cmd_wdata, status_out_q;
    logic [31:0] pwdata, prdata, rd;
    logic [22:0] cmd_addr, map_addr_q;
    logic        cmd_valid, cmd_quad, quad_command_mode, err, ce;
    logic        cmd_done_q, cmd_ok_q, otp_sel_q, otp_mode_q, otp_lock_q;
    logic [42:0] exp_q[$];
    logic [42:0] e;
    logic [19:0] got;
    int          checks = 0;
    int          n_mismatch = 0;
    // ----------------------------------------
    // Design, host model and clock
    // ----------------------------------------
    sfo_otp_ctrl #(.PUW_CYCLES(16)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_quad(cmd_quad), .quad_command_mode(quad_command_mode),
        .cmd_done_q(cmd_done_q), .cmd_ok_q(cmd_ok_q), .otp_sel_q(otp_sel_q),
        .map_addr_q(map_addr_q), .status_out_q(status_out_q), .otp_mode_q(otp_mode_q),
        .otp_lock_q(otp_lock_q));
    sfo_host_model host_u (.pclk(pclk), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_quad(cmd_quad),
        .quad_command_mode(quad_command_mode));
    // Free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // Counted compare with report on mismatch
    task automatic check(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // Count summary, verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One APB transfer held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_mismatch++;
            finish_test();
        end
    endtask
    // Note the expected answer, then offer the instruction
    task automatic c(input logic [7:0] op, input logic [22:0] a, input logic [7:0] d,
                     input logic q, input logic qm, input logic ok, input logic sel,
                     input logic md, input logic lk, input logic [7:0] st = 8'h00);
        exp_q.push_back({a, op, st, ok, sel, md, lk});
        host_u.send(op, a, d, q, qm);
    endtask
    // Monitor: each completion takes the oldest note
    always @(negedge pclk) begin
        if (cmd_done_q === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h0, 32'h1);
            end else begin
                e = exp_q.pop_front();
                got = {e[19:12], (e[19:12] == sfo_pkg::OP_STATUS_READ_CMD) ? status_out_q : e[11:4],
                       cmd_ok_q, otp_sel_q, otp_mode_q, otp_lock_q};
                check({12'h000, got}, {12'h000, e[19:0]});
                check({9'h000, map_addr_q}, {9'h000, e[42:20]});
            end
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int n;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        ce      = 1'b1;
        void'($urandom(70923));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, sfo_pkg::REG_STAT, 32'h0);
        check(rd, 32'h0);
        c(8'h06, 23'h0, 8'h00, 0, 0, 1, 0, 0, 0);
        c(8'h02, 23'h0, 8'h00, 0, 0, 0, 0, 0, 0);
        $display("test power-up done");
        repeat (20) @(posedge pclk);
        apb(1'b1, sfo_pkg::REG_CFG, 32'h1);
        apb(1'b0, sfo_pkg::REG_CFG, 32'h0);
        check(rd, 32'h1);
        c(8'h20, 23'h0, 8'h00, 0, 0, 0, 0, 0, 0);
        apb(1'b1, sfo_pkg::REG_CFG, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        check({rd[30:0], err}, 32'h1);
        c(8'h06, 23'h0, 8'h00, 0, 0, 1, 0, 0, 0);
        c(8'h01, 23'h0, 8'h3C, 0, 0, 1, 0, 0, 0);
        c(8'h3A, 23'h0, 8'h00, 0, 0, 1, 0, 1, 0);
        c(8'h05, 23'h0, 8'h00, 0, 0, 1, 0, 1, 0, 8'h3C);
        c(8'h06, 23'h0, 8'h00, 0, 0, 1, 0, 1, 0);
        c(8'h02, 23'h7FF000, 8'h00, 0, 0, 0, 0, 1, 0);
        c(8'h04, 23'h0, 8'h00, 0, 0, 1, 0, 0, 0);
        c(8'h06, 23'h0, 8'h00, 0, 0, 1, 0, 0, 0);
        c(8'h01, 23'h0, 8'h00, 0, 0, 1, 0, 0, 0);
        c(8'h3A, 23'h0, 8'h00, 0, 1, 0, 0, 0, 0);
        c(8'h3A, 23'h0, 8'h00, 1, 1, 1, 0, 1, 0);
        $display("test entry done");
        c(8'h06, 23'h0, 8'h00, 0, 0, 1, 0, 1, 0);
        c(8'h02, 23'h7FF1FF, 8'h00, 0, 0, 1, 1, 1, 0);
        c(8'h06, 23'h0, 8'h00, 0, 0, 1, 0, 1, 0);
        c(8'h02, 23'h7FF200, 8'h00, 0, 0, 1, 0, 1, 0);
        c(8'h03, {1'b0, 22'($urandom)}, 8'h00, 0, 0, 1, 0, 1, 0);
        c(8'h03, 23'h7FF100, 8'h00, 0, 0, 1, 1, 1, 0);
        c(8'h06, 23'h0, 8'h00, 0, 0, 1, 0, 1, 0);
        c(8'h20, 23'h7FF000, 8'h00, 0, 0, 1, 1, 1, 0);
        c(8'h06, 23'h0, 8'h00, 0, 0, 1, 0, 1, 0);
        c(8'hD8, 23'h7F0000, 8'h00, 0, 0, 0, 0, 1, 0);
        c(8'hC7, 23'h0, 8'h00, 0, 0, 0, 0, 1, 0);
        c(8'h05, 23'h0, 8'h00, 0, 0, 1, 0, 1, 0, 8'h02);
        $display("test secure access done");
        c(8'h01, 23'h0, 8'($urandom), 0, 0, 1, 0, 1, 1);
        c(8'h05, 23'h0, 8'h00, 0, 0, 1, 0, 1, 1, 8'h80);
        c(8'h01, 23'h0, 8'h00, 0, 0, 0, 0, 1, 1);
        c(8'h06, 23'h0, 8'h00, 0, 0, 1, 0, 1, 1);
        c(8'h02, 23'h7FF000, 8'h00, 0, 0, 0, 0, 1, 1);
        c(8'h20, 23'h000000, 8'h00, 0, 0, 0, 0, 1, 1);
        c(8'h03, {1'b0, 22'($urandom)}, 8'h00, 0, 0, 1, 0, 1, 1);
        c(8'h04, 23'h0, 8'h00, 0, 0, 1, 0, 0, 1);
        c(8'h05, 23'h0, 8'h00, 0, 0, 1, 0, 0, 1, 8'h00);
        apb(1'b0, sfo_pkg::REG_STAT, 32'h0);
        check(rd, 32'h600);
        apb(1'b0, sfo_pkg::REG_LAST, 32'h0);
        check(rd, 32'h105);
        $display("test lock done");
        @(posedge pclk);
        ce <= 1'b0;
        host_u.send(8'h3A, 23'h0, 8'h00, 1'b0, 1'b0);
        apb(1'b1, sfo_pkg::REG_CFG, 32'h1);
        @(posedge pclk);
        ce <= 1'b1;
        apb(1'b0, sfo_pkg::REG_CFG, 32'h0);
        check(rd, 32'h0);
        c(8'h05, 23'h0, 8'h00, 0, 0, 1, 0, 0, 1, 8'h00);
        $display("test clock enable done");
        n = 0;
        while (exp_q.size() != 0 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (exp_q.size() != 0) begin
            n_mismatch++;
        end
        finish_test();
    end
endmodule
